// ---- src/chg_pins_pkg.sv ----
package chg_pins_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ctrl_ofs   = 8'h00;
  localparam logic [7:0] status_ofs = 8'h04;
  localparam logic [7:0] irq_ofs    = 8'h08;
  localparam logic [7:0] mask_ofs   = 8'h0c;
  localparam logic [7:0] limit_ofs  = 8'h10;

  // ----------------------------------------------------------------------
  // ctrl field positions
  // ----------------------------------------------------------------------
  localparam int ind_fn_lsb    = 0;
  localparam int charge_bit    = 2;
  localparam int dplus_lsb     = 4;
  localparam int dminus_lsb    = 6;
  localparam int limit_own_bit = 8;

  // ----------------------------------------------------------------------
  // reset values, and the indicator off code
  // ----------------------------------------------------------------------
  localparam logic [1:0] ind_fn_rst    = 2'h0;
  localparam logic       charge_rst    = 1'b1;
  localparam logic [1:0] level_rst     = 2'h0;
  localparam logic [4:0] limit_rst     = 5'h00;
  localparam logic [2:0] mask_rst      = 3'h0;
  localparam logic [1:0] ind_fn_off    = 2'h3;

  // ----------------------------------------------------------------------
  // current limit codes, 100 mA per step from 100 mA
  // ----------------------------------------------------------------------
  localparam logic [4:0] limit_usb_code   = 5'h04;
  localparam logic [4:0] limit_adapt_code = 5'h17;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int clk_mhz       = 250;
  localparam int pulse_us      = 256;
  localparam int pulse_cycles  = pulse_us * clk_mhz;
  localparam int blink_hz      = 1;
  localparam int blink_half_cy = (clk_mhz * 1000000) / (blink_hz * 2);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    chg_idle,
    chg_active,
    chg_done,
    chg_fault
  } chg_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] ind_fn;
    logic       charge_allow;
    logic [1:0] dplus;
    logic [1:0] dminus;
    logic       limit_own;
    logic [4:0] limit;
  } ctrl_t;

  typedef struct packed {
    logic drive_low;
    logic oe;
  } od_pin_t;

endpackage

// ---- src/alert_pulse.sv ----
`timescale 1ns/1ps
module alert_pulse
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic trig,
  output logic      active
);

  typedef struct packed {
    logic        on;
    logic [15:0] cnt;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (s_r.on)
    begin
      // retrigger ignored so a pulse is never cut short
      if (s_r.cnt == 16'(chg_pins_pkg::pulse_cycles - 1))
      begin
        s_nxt.on = 1'b0;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
    else if (trig)
    begin
      s_nxt.on  = 1'b1;
      s_nxt.cnt = 16'h0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign active = s_r.on;

  a_pulse_width_held: assert property (@(posedge core_clk) disable iff (rst)
    $rose(s_r.on) |-> s_r.on [*8])
    else $error("alert pulse ended early");

endmodule

// ---- src/blink_gen.sv ----
`timescale 1ns/1ps
module blink_gen
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      phase
);

  typedef struct packed {
    logic        ph;
    logic [26:0] cnt;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (!run)
    begin
      s_nxt = '0;
    end
    else if (s_r.cnt == 27'(chg_pins_pkg::blink_half_cy - 1))
    begin
      s_nxt.cnt = 27'h0;
      s_nxt.ph  = ~s_r.ph;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 27'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign phase = s_r.ph;

  a_blink_even_duty: assert property (@(posedge core_clk) disable iff (rst)
    run && s_r.cnt != 27'(chg_pins_pkg::blink_half_cy - 1) |=>
    s_r.ph == $past(s_r.ph))
    else $error("blink phase changed mid half period");

endmodule

// ---- src/charger_pins.sv ----
`timescale 1ns/1ps
module charger_pins
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        src_select,
  input  wire logic        charge_allow_pin_n,
  input  wire logic        charging,
  input  wire logic        charge_done,
  input  wire logic        asleep,
  input  wire logic        fault,
  input  wire logic        above_uvlo,
  input  wire logic        below_ovp,
  input  wire logic        above_sleep,
  input  wire logic        weak_src_ok,
  output logic             stat_out,
  output logic             stat_oe,
  output logic             host_alert_pin_out,
  output logic             host_alert_pin_oe,
  output logic             input_good_pin_out,
  output logic             input_good_pin_oe,
  output logic             charge_enable,
  output logic [4:0]       input_current_limit,
  output logic [1:0]       dplus_level,
  output logic [1:0]       dminus_level,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    chg_pins_pkg::bus_req_t   req;
    logic [31:0]              rdata;
    chg_pins_pkg::ctrl_t      ctrl;
    logic [2:0]               irq_stat;
    logic [2:0]               irq_mask;
    chg_pins_pkg::chg_state_t cst;
    logic                     fault_d;
    chg_pins_pkg::od_pin_t    stat;
    chg_pins_pkg::od_pin_t    alert;
    chg_pins_pkg::od_pin_t    good;
    logic                     chg_en;
    logic [4:0]               limit;
    logic [1:0]               dp;
    logic [1:0]               dm;
    logic                     irq;
  } st_t;

  st_t  s_r;
  st_t  s_nxt;
  logic status_evt;
  logic pulse_on;
  logic blink_ph;

  function automatic logic [31:0] ctrl_word(chg_pins_pkg::ctrl_t c);
    logic [31:0] w;
    w = 32'h0;
    w[chg_pins_pkg::ind_fn_lsb +: 2]  = c.ind_fn;
    w[chg_pins_pkg::charge_bit]       = c.charge_allow;
    w[chg_pins_pkg::dplus_lsb +: 2]   = c.dplus;
    w[chg_pins_pkg::dminus_lsb +: 2]  = c.dminus;
    w[chg_pins_pkg::limit_own_bit]    = c.limit_own;
    return w;
  endfunction

  function automatic chg_pins_pkg::chg_state_t classify(
    logic chg, logic done, logic slp, logic flt);
    chg_pins_pkg::chg_state_t r;
    r = chg_pins_pkg::chg_idle;
    if (flt)
      r = chg_pins_pkg::chg_fault;
    else if (chg)
      r = chg_pins_pkg::chg_active;
    else if (done || slp)
      r = chg_pins_pkg::chg_done;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  alert_pulse u_pulse
  (
    .core_clk (core_clk),
    .rst      (rst),
    .trig     (status_evt),
    .active   (pulse_on)
  );

  blink_gen u_blink
  (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (s_r.cst == chg_pins_pkg::chg_fault),
    .phase    (blink_ph)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    chg_pins_pkg::chg_state_t ncst;
    logic                     wr;
    logic [2:0]               ev;
    ncst  = classify(charging, charge_done, asleep, fault);
    wr    = 1'b0;
    ev    = 3'h0;
    s_nxt = s_r;

    // bus: capture address phase, act in data phase, zero wait
    s_nxt.req.valid = hsel && hready && htrans[1];
    s_nxt.req.write = hwrite;
    s_nxt.req.addr  = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        chg_pins_pkg::ctrl_ofs:   s_nxt.rdata = ctrl_word(s_r.ctrl);
        chg_pins_pkg::status_ofs: s_nxt.rdata = {27'h0, s_r.stat.drive_low,
                                  s_r.chg_en, s_r.fault_d, s_r.cst};
        chg_pins_pkg::irq_ofs:    s_nxt.rdata = {29'h0, s_r.irq_stat};
        chg_pins_pkg::mask_ofs:   s_nxt.rdata = {29'h0, s_r.irq_mask};
        chg_pins_pkg::limit_ofs:  s_nxt.rdata = {27'h0, s_r.limit};
        default:                  s_nxt.rdata = 32'h0;
      endcase
    end
    wr = s_r.req.valid && s_r.req.write;

    // events: bit0 status change, bit1 fault rise, bit2 good change
    ev[0] = ncst != s_r.cst;
    ev[1] = fault && !s_r.fault_d;
    // taken from the pins, the good flag is only filled in further down
    ev[2] = (above_uvlo && below_ovp && above_sleep && weak_src_ok)
            != s_r.good.oe;

    // write-one-clear, but a new event wins over the clear
    if (wr && s_r.req.addr == chg_pins_pkg::irq_ofs)
      s_nxt.irq_stat = s_r.irq_stat & ~hwdata[2:0];
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    if (wr && s_r.req.addr == chg_pins_pkg::mask_ofs)
      s_nxt.irq_mask = hwdata[2:0];
    if (wr && s_r.req.addr == chg_pins_pkg::ctrl_ofs)
    begin
      s_nxt.ctrl.ind_fn       = hwdata[chg_pins_pkg::ind_fn_lsb +: 2];
      s_nxt.ctrl.charge_allow = hwdata[chg_pins_pkg::charge_bit];
      s_nxt.ctrl.dplus        = hwdata[chg_pins_pkg::dplus_lsb +: 2];
      s_nxt.ctrl.dminus       = hwdata[chg_pins_pkg::dminus_lsb +: 2];
    end
    if (wr && s_r.req.addr == chg_pins_pkg::limit_ofs)
    begin
      s_nxt.ctrl.limit     = hwdata[4:0];
      s_nxt.ctrl.limit_own = 1'b1;
    end

    s_nxt.cst     = ncst;
    s_nxt.fault_d = fault;

    // status pin pattern
    case (s_r.cst)
      chg_pins_pkg::chg_active: s_nxt.stat.drive_low = 1'b1;
      chg_pins_pkg::chg_fault:  s_nxt.stat.drive_low = blink_ph;
      chg_pins_pkg::chg_done:   s_nxt.stat.drive_low = 1'b0;
      default:                  s_nxt.stat.drive_low = 1'b0;
    endcase
    if (s_r.ctrl.ind_fn == chg_pins_pkg::ind_fn_off)
      s_nxt.stat.drive_low = 1'b0;
    s_nxt.stat.oe = s_nxt.stat.drive_low;

    s_nxt.alert.drive_low = pulse_on;
    s_nxt.alert.oe        = pulse_on;

    s_nxt.good.drive_low = above_uvlo && below_ovp && above_sleep
                           && weak_src_ok;
    s_nxt.good.oe        = s_nxt.good.drive_low;

    s_nxt.chg_en = s_r.ctrl.charge_allow && !charge_allow_pin_n;

    if (s_r.ctrl.limit_own)
      s_nxt.limit = s_r.ctrl.limit;
    else if (src_select)
      s_nxt.limit = chg_pins_pkg::limit_usb_code;
    else
      s_nxt.limit = chg_pins_pkg::limit_adapt_code;

    s_nxt.dp  = s_r.ctrl.dplus;
    s_nxt.dm  = s_r.ctrl.dminus;
    s_nxt.irq = |(s_r.irq_stat & s_r.irq_mask);
  end

  assign status_evt = (classify(charging, charge_done, asleep, fault)
                       != s_r.cst) || (fault && !s_r.fault_d);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_r                   <= '0;
      s_r.ctrl.ind_fn       <= chg_pins_pkg::ind_fn_rst;
      s_r.ctrl.charge_allow <= chg_pins_pkg::charge_rst;
      s_r.ctrl.dplus        <= chg_pins_pkg::level_rst;
      s_r.ctrl.dminus       <= chg_pins_pkg::level_rst;
      s_r.ctrl.limit        <= chg_pins_pkg::limit_rst;
      s_r.irq_mask          <= chg_pins_pkg::mask_rst;
      s_r.limit             <= chg_pins_pkg::limit_adapt_code;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, registered or tied to constants
  // ----------------------------------------------------------------------
  assign hrdata              = s_r.rdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign stat_out            = 1'b0;
  assign stat_oe             = s_r.stat.oe;
  assign host_alert_pin_out  = 1'b0;
  assign host_alert_pin_oe   = s_r.alert.oe;
  assign input_good_pin_out  = 1'b0;
  assign input_good_pin_oe   = s_r.good.oe;
  assign charge_enable       = s_r.chg_en;
  assign input_current_limit = s_r.limit;
  assign dplus_level         = s_r.dp;
  assign dminus_level        = s_r.dm;
  assign irq                 = s_r.irq;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_stat_charge_low: assert property (@(posedge core_clk) disable iff (rst)
    s_r.cst == chg_pins_pkg::chg_active && s_r.ctrl.ind_fn
    != chg_pins_pkg::ind_fn_off ##1 1'b1 |-> stat_oe)
    else $error("status pin not low while charging");
  a_stat_done_high: assert property (@(posedge core_clk) disable iff (rst)
    $past(s_r.cst) == chg_pins_pkg::chg_done |-> !stat_oe)
    else $error("status pin driven after charge done");
  a_stat_disabled: assert property (@(posedge core_clk) disable iff (rst)
    $past(s_r.ctrl.ind_fn) == chg_pins_pkg::ind_fn_off |-> !stat_oe)
    else $error("status pin active while disabled");
  a_od_never_high: assert property (@(posedge core_clk) disable iff (rst)
    !stat_out && !host_alert_pin_out)
    else $error("open drain pin driven high");
  a_alert_follows_evt: assert property (@(posedge core_clk) disable iff (rst)
    status_evt && !pulse_on |-> ##2 host_alert_pin_oe)
    else $error("no alert pulse after event");
  a_alert_idle_off: assert property (@(posedge core_clk) disable iff (rst)
    !$past(pulse_on) |-> !host_alert_pin_oe)
    else $error("alert driven while idle");
  a_limit_select: assert property (@(posedge core_clk) disable iff (rst)
    !s_r.ctrl.limit_own && src_select ##1 !$past(s_r.ctrl.limit_own)
    |-> input_current_limit == chg_pins_pkg::limit_usb_code)
    else $error("usb limit not applied");
  a_limit_adaptor: assert property (@(posedge core_clk) disable iff (rst)
    !s_r.ctrl.limit_own && !src_select |=>
    input_current_limit == chg_pins_pkg::limit_adapt_code)
    else $error("adaptor limit not applied");
  a_charge_gate: assert property (@(posedge core_clk) disable iff (rst)
    charge_enable |-> $past(s_r.ctrl.charge_allow)
    && !$past(charge_allow_pin_n))
    else $error("charging enabled without both conditions");
  a_good_window: assert property (@(posedge core_clk) disable iff (rst)
    input_good_pin_oe |-> $past(above_uvlo && below_ovp && above_sleep
    && weak_src_ok))
    else $error("input good without valid input");

  c_fault_blink: cover property (@(posedge core_clk)
    s_r.cst == chg_pins_pkg::chg_fault && stat_oe);
  c_alert_pulse: cover property (@(posedge core_clk) $rose(host_alert_pin_oe));
  c_limit_write: cover property (@(posedge core_clk) $rose(s_r.ctrl.limit_own));

endmodule

// ---- verif/host_pin_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// host side of the open-drain pins: pull-ups resolve the wire level
// ----------------------------------------------------------------------
module host_pin_model
(
  input  wire logic stat_out,
  input  wire logic stat_oe,
  input  wire logic alert_out,
  input  wire logic alert_oe,
  input  wire logic good_out,
  input  wire logic good_oe,
  output logic      stat_lvl,
  output logic      alert_lvl,
  output logic      good_lvl
);
  // released pin floats up to the rail, never keeps its last value
  assign stat_lvl  = stat_oe ? stat_out : 1'b1;
  assign alert_lvl = alert_oe ? alert_out : 1'b1;
  assign good_lvl  = good_oe ? good_out : 1'b1;
endmodule

// ---- verif/test_charger_pins.sv ----
`timescale 1ns/1ps
module test_charger_pins;
  logic        core_clk, rst, hsel, hwrite, src_select, pin_n;
  logic        charging, charge_done, asleep, fault;
  logic        hready, hreadyout, hresp, irq, charge_enable;
  logic        stat_out, stat_oe, alert_out, alert_oe, good_out, good_oe;
  logic        stat_lvl, alert_lvl, good_lvl;
  logic [1:0]  htrans, dplus_level, dminus_level;
  logic [2:0]  hsize;
  logic [3:0]  good_in;
  logic [4:0]  lim;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          failures, samples_checked, cnt;

  // ----------------------------------------------------------------------
  // clock, design, host
  // ----------------------------------------------------------------------
  always #2 core_clk = ~core_clk;
  assign hready = hreadyout;

  charger_pins dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_select(src_select),
    .charge_allow_pin_n(pin_n), .charging(charging),
    .charge_done(charge_done), .asleep(asleep), .fault(fault),
    .above_uvlo(good_in[3]), .below_ovp(good_in[2]),
    .above_sleep(good_in[1]), .weak_src_ok(good_in[0]),
    .stat_out(stat_out), .stat_oe(stat_oe),
    .host_alert_pin_out(alert_out), .host_alert_pin_oe(alert_oe),
    .input_good_pin_out(good_out), .input_good_pin_oe(good_oe),
    .charge_enable(charge_enable), .input_current_limit(lim),
    .dplus_level(dplus_level), .dminus_level(dminus_level), .irq(irq));

  host_pin_model host (.stat_out(stat_out), .stat_oe(stat_oe),
    .alert_out(alert_out), .alert_oe(alert_oe), .good_out(good_out),
    .good_oe(good_oe), .stat_lvl(stat_lvl), .alert_lvl(alert_lvl),
    .good_lvl(good_lvl));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s", $time, msg);
      failures++;
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  // single word transfer, zero wait slave but master waits on hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task automatic conclude();
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, chg_pins_pkg::ctrl_ofs, 32'h0, rd);
    chk(rd, 32'h4, "ctrl reset value");
    bus(1'b0, chg_pins_pkg::mask_ofs, 32'h0, rd);
    chk(rd, 32'h0, "mask reset value");
    bus(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    chk(32'(alert_lvl), 32'h1, "alert not idle high");
    chk(32'(hresp), 32'h0, "hresp not okay");
  endtask

  // one pulse, a second event mid-pulse must neither extend nor cut it
  task automatic t_alert();
    charging <= 1'b1;
    cnt = 0;
    while (alert_lvl !== 1'b0 && cnt < 8)
    begin
      @(posedge core_clk);
      cnt++;
    end
    chk(32'(alert_lvl), 32'h0, "no alert pulse");
    cnt = 0;
    while (alert_lvl === 1'b0 && cnt < 70000)
    begin
      @(posedge core_clk);
      cnt++;
      if (cnt == 1000)
        fault <= 1'b1;
      if (cnt == 2000)
        chk(32'(stat_lvl), 32'h1, "blink not released first");
    end
    chk(cnt, 32'(chg_pins_pkg::pulse_cycles), "pulse width");
    settle();
    chk(32'(alert_lvl), 32'h1, "pulse retriggered");
  endtask

  task automatic t_stat();
    fault    <= 1'b0;
    settle();
    chk(32'(stat_lvl), 32'h0, "stat not low charging");
    chk(32'(stat_out), 32'h0, "open drain drives high");
    charging    <= 1'b0;
    charge_done <= 1'b1;
    settle();
    chk(32'(stat_lvl), 32'h1, "stat low when done");
    charge_done <= 1'b0;
    asleep      <= 1'b1;
    settle();
    chk(32'(stat_lvl), 32'h1, "stat low asleep");
    asleep <= 1'b0;
    pin_n  <= 1'b0;
    settle();
    chk(32'(charge_enable), 32'h1, "charge not enabled");
    bus(1'b1, chg_pins_pkg::ctrl_ofs, 32'h0, rd);
    settle();
    chk(32'(charge_enable), 32'h0, "charge on, bit clear");
  endtask

  task automatic t_levels();
    charging <= 1'b1;
    bus(1'b1, chg_pins_pkg::ctrl_ofs, 32'h64, rd);
    settle();
    chk(32'(dplus_level), 32'h2, "d+ level");
    chk(32'(dminus_level), 32'h1, "d- level");
    bus(1'b1, chg_pins_pkg::ctrl_ofs, 32'h67, rd);
    settle();
    chk(32'(stat_lvl), 32'h1, "stat shown while off");
    bus(1'b1, chg_pins_pkg::ctrl_ofs, 32'h64, rd);
    settle();
    chk(32'(stat_lvl), 32'h0, "stat not back on");
  endtask

  task automatic t_source();
    src_select <= 1'b1;
    settle();
    chk(32'(lim), 32'(chg_pins_pkg::limit_usb_code), "usb limit");
    src_select <= 1'b0;
    settle();
    chk(32'(lim), 32'(chg_pins_pkg::limit_adapt_code), "adaptor");
    bus(1'b1, chg_pins_pkg::limit_ofs, 32'h9, rd);
    src_select <= 1'b1;
    settle();
    chk(32'(lim), 32'h9, "host limit lost");
    bus(1'b0, chg_pins_pkg::limit_ofs, 32'h0, rd);
    chk(rd, 32'h9, "limit readback");
  endtask

  task automatic t_good();
    for (int i = 0; i < 5; i++)
    begin
      good_in <= (i < 4) ? ~(4'h1 << i) : 4'hf;
      settle();
      chk(32'(good_lvl), (i < 4) ? 32'h1 : 32'h0, "input good");
    end
    bus(1'b0, chg_pins_pkg::irq_ofs, 32'h0, rd);
    chk(rd & 32'h4, 32'h4, "good change bit");
  endtask

  // sticky status, mask, write one to clear
  task automatic t_irq();
    bus(1'b1, chg_pins_pkg::mask_ofs, 32'h7, rd);
    charging <= 1'b0;
    settle();
    bus(1'b1, chg_pins_pkg::irq_ofs, 32'h7, rd);
    settle();
    chk(32'(irq), 32'h0, "irq after clear");
    charging <= 1'b1;
    settle();
    bus(1'b0, chg_pins_pkg::irq_ofs, 32'h0, rd);
    chk(rd, 32'h1, "state change bit");
    chk(32'(irq), 32'h1, "irq not raised");
    bus(1'b1, chg_pins_pkg::mask_ofs, 32'h6, rd);
    settle();
    chk(32'(irq), 32'h0, "irq not masked");
    bus(1'b1, chg_pins_pkg::mask_ofs, 32'h7, rd);
    settle();
    chk(32'(irq), 32'h1, "irq not unmasked");
    fault <= 1'b1;
    settle();
    bus(1'b0, chg_pins_pkg::irq_ofs, 32'h0, rd);
    chk(rd, 32'h3, "fault bit");
    bus(1'b1, chg_pins_pkg::irq_ofs, 32'h3, rd);
    bus(1'b0, chg_pins_pkg::irq_ofs, 32'h0, rd);
    chk(rd, 32'h0, "status not cleared");
    settle();
    chk(32'(irq), 32'h0, "irq after clear");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    src_select = 1'b0; pin_n = 1'b1; charging = 1'b0;
    charge_done = 1'b0; asleep = 1'b0; fault = 1'b0; good_in = 4'hf;
    failures = 0; samples_checked = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_alert();
    t_stat();
    t_levels();
    t_source();
    t_good();
    t_irq();
    conclude();
  end

  // the long pulse dominates: about 64200 cycles expected
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    conclude();
  end
endmodule
